// >>> core/flow_through_burst_sram_access.sv
/*
  Access control of a flow-through burst SRAM with common data pins split into in, out and enable.
  Assumes the controller drives all synchronous inputs in step with REF_CLK and keeps off the
  data pins while the outputs are enabled.
*/
module flow_through_burst_sram_access
  import sram_access_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEFAULT,
  parameter int BYTES = BYTES_DEFAULT
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic CLOCK_QUALIFIER_N,
  input wire logic CHIP_SELECT_ONE_N,
  input wire logic CHIP_SELECT_TWO,
  input wire logic CHIP_SELECT_THREE_N,
  input wire logic ADVANCE_LOAD,
  input wire logic WRITE_ENABLE_N,
  input wire logic [BYTES-1:0] BYTE_WRITE_SELECT_N,
  input wire logic [ADDR_W-1:0] ADDRESS,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic BURST_ORDER,
  input wire logic [BYTES*DATA_BITS-1:0] DQ_IN,
  input wire logic [BYTES-1:0] PARITY_DATA_LINES_IN,
  output logic [BYTES*DATA_BITS-1:0] DQ_OUT,
  output logic [BYTES-1:0] PARITY_DATA_LINES_OUT,
  output logic DQ_OE
);

  if (ADDR_W < BEAT_W + 1 || ADDR_W > 24 || BYTES < 1 || BYTES > 8) begin : g_check
    $error("Unsupported address width or byte count");
  end

  typedef enum logic [1:0] {
    CMD_ADVANCE,
    CMD_DESELECT,
    CMD_LOAD_READ,
    CMD_LOAD_WRITE
  } cmd_t;

  cmd_t cmd;
  burst_t burst;
  burst_t next_burst;
  logic [ADDR_W-1:0] base_addr;
  logic [ADDR_W-1:0] next_base_addr;
  logic wr_pend;
  logic next_wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [BYTES-1:0] wr_be;
  logic [BYTES-1:0] next_wr_be;
  logic [ADDR_W-1:0] beat_addr;
  logic [BYTES*LANE_W-1:0] wr_word;
  logic [BYTES*LANE_W-1:0] rd_word;
  logic selected;
  logic qualified;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  assign qualified = !CLOCK_QUALIFIER_N;
  assign selected = !CHIP_SELECT_ONE_N && CHIP_SELECT_TWO && !CHIP_SELECT_THREE_N;

  // Advance outranks the selects, so a stray select cannot cut a burst
  always_comb begin
    if (ADVANCE_LOAD) begin
      cmd = CMD_ADVANCE;
    end else if (!selected) begin
      cmd = CMD_DESELECT;
    end else if (WRITE_ENABLE_N) begin
      cmd = CMD_LOAD_READ;
    end else begin
      cmd = CMD_LOAD_WRITE;
    end
  end

  always_comb begin
    next_burst = burst;
    next_base_addr = base_addr;
    unique case (cmd)
      CMD_ADVANCE: begin
        // Direction kept from the load; advance while idle stays idle
        if (burst.op != OP_IDLE) begin
          next_burst.idx = burst.idx + BEAT_STEP;
        end
      end
      CMD_LOAD_READ, CMD_LOAD_WRITE: begin
        next_base_addr = ADDRESS;
        next_burst.base_lo = ADDRESS[BEAT_W-1:0];
        next_burst.idx = BEAT_FIRST;
        next_burst.op = (cmd == CMD_LOAD_READ) ? OP_READ : OP_WRITE;
      end
      CMD_DESELECT: begin
        next_burst.op = OP_IDLE;
      end
    endcase
    // Only the two low bits move; upper bits stay at the loaded address
    beat_addr = {next_base_addr[ADDR_W-1:BEAT_W],
                 beat_lo(BURST_ORDER, next_burst.base_lo, next_burst.idx)};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending write: controls now, data on the following qualified edge
  always_comb begin
    next_wr_pend = (next_burst.op == OP_WRITE);
    next_wr_addr = beat_addr;
    next_wr_be = ~BYTE_WRITE_SELECT_N;
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      burst <= BURST_RESET;
      base_addr <= '0;
      wr_pend <= 1'b0;
      wr_addr <= '0;
      wr_be <= '0;
    end else if (qualified) begin
      burst <= next_burst;
      base_addr <= next_base_addr;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      wr_be <= next_wr_be;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane packing: each lane is parity bit over eight data bits
  always_comb begin
    wr_word = '0;
    DQ_OUT = '0;
    PARITY_DATA_LINES_OUT = '0;
    for (int b = 0; b < BYTES; b++) begin
      wr_word[b*LANE_W +: LANE_W] = {PARITY_DATA_LINES_IN[b], DQ_IN[b*DATA_BITS +: DATA_BITS]};
      PARITY_DATA_LINES_OUT[b] = rd_word[b*LANE_W + DATA_BITS];
      DQ_OUT[b*DATA_BITS +: DATA_BITS] = rd_word[b*LANE_W +: DATA_BITS];
    end
  end

  sram_lane_mem #(
    .ADDR_W(ADDR_W),
    .BYTES(BYTES)
  ) u_mem (
    .clk(REF_CLK),
    .en(qualified && RST_B),
    .we(wr_pend),
    .be(wr_be),
    .waddr(wr_addr),
    .wdata(wr_word),
    .re(next_burst.op == OP_READ),
    .raddr(beat_addr),
    .rdata(rd_word)
  );

  // Output enable is asynchronous; masked in write and deselect cycles
  assign DQ_OE = (burst.op == OP_READ) && !OUTPUT_ENABLE_N;

endmodule

// >>> include/sram_access_pkg.sv
/*
  Shared constants, types and burst arithmetic for the flow-through burst SRAM access logic.
  Assumes a single rising-edge clock domain and synchronous inputs.
*/
package sram_access_pkg;

  localparam int ADDR_W_DEFAULT = 20;
  localparam int BYTES_DEFAULT = 2;
  localparam int DATA_BITS = 8;
  localparam int LANE_W = DATA_BITS + 1;
  localparam int BEAT_W = 2;
  localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;
  localparam logic BURST_LINEAR = 1'h0;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_t;

  typedef struct packed {
    op_t op;
    logic [BEAT_W-1:0] base_lo;
    logic [BEAT_W-1:0] idx;
  } burst_t;

  localparam burst_t BURST_RESET = '{op: OP_IDLE, base_lo: BEAT_FIRST, idx: BEAT_FIRST};

  function automatic logic [BEAT_W-1:0] beat_lo(input logic order, input logic [BEAT_W-1:0] base,
                                                input logic [BEAT_W-1:0] idx);
    beat_lo = (order == BURST_LINEAR) ? base + idx : base ^ idx;
  endfunction

endpackage

// >>> core/sram_lane_mem.sv
/*
  Byte-lane memory array with registered read data and per-lane write enables.
  Assumes one clock; a read and a write at one edge to one word return the new lanes.
*/
module sram_lane_mem
  import sram_access_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEFAULT,
  parameter int BYTES = BYTES_DEFAULT
) (
  input wire logic clk,
  input wire logic en,
  input wire logic we,
  input wire logic [BYTES-1:0] be,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [BYTES*LANE_W-1:0] wdata,
  input wire logic re,
  input wire logic [ADDR_W-1:0] raddr,
  output logic [BYTES*LANE_W-1:0] rdata
);

  logic [BYTES*LANE_W-1:0] mem [0:(2**ADDR_W)-1];
  logic [BYTES*LANE_W-1:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Bypass so a read right after a write sees the written lanes
  always_comb begin
    next_rdata = rdata;
    if (en && re) begin
      next_rdata = mem[raddr];
      for (int b = 0; b < BYTES; b++) begin
        if (we && be[b] && waddr == raddr) begin
          next_rdata[b*LANE_W +: LANE_W] = wdata[b*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    rdata <= next_rdata;
    if (en && we) begin
      for (int b = 0; b < BYTES; b++) begin
        if (be[b]) begin
          mem[waddr][b*LANE_W +: LANE_W] <= wdata[b*LANE_W +: LANE_W];
        end
      end
    end
  end

endmodule

// >>> tb/sram_access_checker.sv
/* Port assertions for the burst SRAM access block.
   Bound into the top module; one clock, RST_B active low. */
module sram_access_checker
  import sram_access_pkg::*;
#(parameter int ADDR_W = ADDR_W_DEFAULT, parameter int BYTES = BYTES_DEFAULT) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic CLOCK_QUALIFIER_N,
  input wire logic CHIP_SELECT_ONE_N,
  input wire logic CHIP_SELECT_TWO,
  input wire logic CHIP_SELECT_THREE_N,
  input wire logic ADVANCE_LOAD,
  input wire logic WRITE_ENABLE_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic BURST_ORDER,
  input wire logic DQ_OE,
  input wire logic [BYTES-1:0] BYTE_WRITE_SELECT_N,
  input wire logic [BYTES-1:0] PARITY_DATA_LINES_IN,
  input wire logic [BYTES-1:0] PARITY_DATA_LINES_OUT,
  input wire logic [ADDR_W-1:0] ADDRESS,
  input wire logic [BYTES*DATA_BITS-1:0] DQ_IN,
  input wire logic [BYTES*DATA_BITS-1:0] DQ_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic sel = !CHIP_SELECT_ONE_N && CHIP_SELECT_TWO && !CHIP_SELECT_THREE_N;
  wire logic ld = !CLOCK_QUALIFIER_N && !ADVANCE_LOAD;
  wire logic oe = !OUTPUT_ENABLE_N;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_wr; ld && sel && !WRITE_ENABLE_N; endsequence
  sequence s_adv; !CLOCK_QUALIFIER_N && ADVANCE_LOAD; endsequence
  property p_rd; ld && sel && WRITE_ENABLE_N |=> DQ_OE == oe; endproperty
  a_rd: assert property (p_rd) else $error("read not driven");
  property p_oe; !oe |-> !DQ_OE; endproperty
  a_oe: assert property (p_oe) else $error("drive with oe off");
  property p_brd; DQ_OE ##0 s_adv |=> DQ_OE == oe; endproperty
  a_brd: assert property (p_brd) else $error("read burst lost");
  property p_wr; s_wr |=> !DQ_OE; endproperty
  a_wr: assert property (p_wr) else $error("drive in write");
  property p_bwr; s_wr ##1 s_adv |=> !DQ_OE; endproperty
  a_bwr: assert property (p_bwr) else $error("drive in write burst");
  property p_des; ld && !sel |=> !DQ_OE; endproperty
  a_des: assert property (p_des) else $error("drive when deselected");
  property p_stl; CLOCK_QUALIFIER_N && DQ_OE |=> $stable(DQ_OUT) && DQ_OE == oe; endproperty
  a_stl: assert property (p_stl) else $error("stall changed read");
  property p_rst; disable iff (1'b0) !RST_B |=> !DQ_OE; endproperty
  a_rst: assert property (p_rst) else $error("drive after reset");
endmodule

bind flow_through_burst_sram_access sram_access_checker #(.ADDR_W(ADDR_W), .BYTES(BYTES))
  u_sram_access_checker (.*);

// >>> tb/sram_ctl_model.sv
/* Data side of the memory controller: supplies write data on the shared bus.
   Assumes two byte lanes and the device's drive enable as input. */
module sram_ctl_model (
  input wire logic clk,
  input wire logic dev_oe,
  input wire logic [17:0] wdata,
  output logic [17:0] bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] last = 18'h0;
  always @(posedge clk) last <= bus;
  // Released bus shows inverse of last value, so stale data never matches
  assign bus = (dev_oe === 1'b1) ? ~last : wdata;
endmodule

// >>> tb/testbench.sv
/* Self-checking bench for the burst SRAM access block.
   Bench drives commands at the falling edge; the controller model drives data. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [19:0] a; logic [1:0] bw; logic [17:0] d, e; logic [2:0] ds;} row_t;
  localparam logic [2:0] SEL = 3'h2;
  localparam logic [2:0] DES = 3'h6;
  row_t rows [5] = '{'{20'h10, 2'h0, 18'h2c3a5, 18'h2c3a5, 3'h6}, '{20'h20, 2'h0, 18'h0aaaa, 18'h0aaaa, 3'h0},
    '{20'h20, 2'h2, 18'h35555, 18'h1aa55, 3'h3}, '{20'h10, 2'h1, 18'h15a5a, 18'h05aa5, 3'h7},
    '{20'h20, 2'h3, 18'h0, 18'h1aa55, 3'h6}};
  logic clk = 1'b0, rst_b = 1'b0, q_n = 1'b0, cs1_n = 1'b1, cs2 = 1'b0, cs3_n = 1'b0, adv = 1'b0;
  logic we_n = 1'b1, oe_n = 1'b0, order = 1'b0, dq_oe;
  logic [1:0] bw_n = 2'h0, par_out;
  logic [19:0] addr = 20'h0;
  logic [17:0] wdata = 18'h0, bus;
  logic [15:0] dq_out;
  int n_fail = 0, checks_done = 0, cycles = 0;
  always #4 clk = ~clk;
  flow_through_burst_sram_access u_flow_through_burst_sram_access (.REF_CLK(clk), .RST_B(rst_b),
    .CLOCK_QUALIFIER_N(q_n), .CHIP_SELECT_ONE_N(cs1_n), .CHIP_SELECT_TWO(cs2), .CHIP_SELECT_THREE_N(cs3_n),
    .ADVANCE_LOAD(adv), .WRITE_ENABLE_N(we_n), .BYTE_WRITE_SELECT_N(bw_n), .ADDRESS(addr),
    .OUTPUT_ENABLE_N(oe_n), .BURST_ORDER(order), .DQ_IN(bus[15:0]), .PARITY_DATA_LINES_IN(bus[17:16]),
    .DQ_OUT(dq_out), .PARITY_DATA_LINES_OUT(par_out), .DQ_OE(dq_oe));
  sram_ctl_model u_sram_ctl_model (.clk(clk), .dev_oe(dq_oe), .wdata(wdata), .bus(bus));
  //////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d failed %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Falling-edge drive keeps setup clear of the sampling edge
  task automatic cyc(input logic [2:0] cs, input logic q, a, w, input logic [1:0] b,
                     input logic [19:0] ad, input logic [17:0] d);
    @(negedge clk);
    {cs1_n, cs2, cs3_n, q_n, adv, we_n, bw_n, addr, wdata} = {cs, q, a, w, b, ad, d};
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 400) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 chk({17'h0, dq_oe}, 18'h0);
    @(negedge clk) rst_b = 1'b1;
    foreach (rows[i]) begin
      cyc(SEL, 0, 0, 0, rows[i].bw, rows[i].a, 18'h0);
      cyc(SEL, 0, 0, 1, 2'h0, rows[i].a, rows[i].d);
      #1 chk({par_out, dq_out}, rows[i].e);
      cyc(rows[i].ds, 0, 0, 1, 2'h0, 20'h0, 18'h0);
      #1 chk({17'h0, dq_oe}, 18'h0);
    end
    $display("rows done");
    cyc(SEL, 0, 0, 0, 2'h0, 20'h11, 18'h0);
    for (int k = 0; k < 4; k++) cyc(DES, 0, k < 3, 1, 2'h0, 20'h0, 18'(18'h100 + k));
    @(negedge clk) order = 1'b1;
    for (int k = 0; k < 4; k++) begin
      cyc(SEL, 0, k > 0, 1, 2'h3, 20'h11, 18'h0);
      #1 chk({par_out, dq_out}, 18'(18'h100 + (((1 ^ k) - 1) & 3)));
    end
    $display("burst done");
    cyc(SEL, 0, 0, 0, 2'h0, 20'h30, 18'h0);
    cyc(SEL, 1, 0, 1, 2'h0, 20'h30, 18'h3dead);
    cyc(SEL, 0, 0, 1, 2'h0, 20'h30, 18'h0beef);
    #1 chk({par_out, dq_out}, 18'h0beef);
    cyc(DES, 1, 0, 1, 2'h0, 20'h0, 18'h0);
    #1 chk({dq_oe, par_out, dq_out[14:0]}, {1'b1, 2'h0, 15'h3eef});
    @(negedge clk) oe_n = 1'b1;
    #1 chk({17'h0, dq_oe}, 18'h0);
    $display("stall done");
    cyc(SEL, 0, 0, 0, 2'h0, 20'h30, 18'h0);
    // Reset with qualifier high and outputs enabled must drop the pending write
    @(negedge clk) {rst_b, q_n, oe_n} = 3'h2;
    @(posedge clk) #1 chk({17'h0, dq_oe}, 18'h0);
    @(negedge clk) rst_b = 1'b1;
    cyc(SEL, 0, 0, 1, 2'h0, 20'h30, 18'h12345);
    #1 chk({par_out, dq_out}, 18'h0beef);
    $display("reset done");
    give_verdict();
  end
endmodule
